// ---- logic/qdc_top.sv ----
// command decoder and input/converter registers of the quad converter
`timescale 1ns/1ps

module qdc_top
   import qdc_pkg::*;
#(
   parameter int DATA_W = QDC_DATA_BITS, // converter code width
   parameter int CHANNELS = QDC_CHANNELS // number of converters
)
(
   input wire logic i_clk_sys, // system clock, 50 MHz
   input wire logic i_rst_n, // synchronous reset, active low
   input wire logic i_sclk, // serial clock from host
   input wire logic i_cs_n, // chip select, active low
   input wire logic i_serial_in, // serial data in
   input wire logic i_dac_load_strobe_n, // converter load strobe, active low
   output logic o_serial_out, // serial data out level
   output logic o_serial_out_oe_n, // serial out enable, low drives
   output logic [CHANNELS-1:0][DATA_W-1:0] o_dac_code, // converter register codes
   output logic [CHANNELS-1:0][DATA_W-1:0] o_input_code, // input register codes
   output logic o_edge_falling, // 1 when serial out uses falling edge
   output logic o_cmd_done // pulse when a command was carried out
);

   // refuse shapes the fixed word layout cannot serve
   if (DATA_W != QDC_DATA_BITS || CHANNELS != QDC_CHANNELS) begin : g_bad_shape
      $error("qdc_top supports only 12-bit codes and four channels");
   end

   // one-hot channel mask from the two channel bits
   function automatic logic [QDC_CHANNELS-1:0] fn_chan_mask(input logic [QDC_CH_W-1:0] sel);
      logic [QDC_CHANNELS-1:0] m;
      m = '0;
      m[sel] = 1'b1;
      return m;
   endfunction

   // copy of all input codes into converter codes
   function automatic qdc_codes_t fn_update_all(input qdc_codes_t ins);
      return ins;
   endfunction

   qdc_link_if u_link_if ();

   qdc_core_t st;
   qdc_core_t next_st;

   // decoded fields of the captured word
   logic [QDC_CH_W-1:0] chan;
   logic [QDC_CMD_W-1:0] cmd;
   logic [QDC_DATA_BITS-1:0] data;
   logic [QDC_CHANNELS-1:0] mask;
   logic strobe_high;

   // serial-clock side: shift register and serial output
   qdc_serial_link u_serial_link (
      .i_sclk(i_sclk),
      .i_rst_n(i_rst_n),
      .i_cs_n(i_cs_n),
      .i_serial_in(i_serial_in),
      .o_serial_out(o_serial_out),
      .o_serial_out_oe_n(o_serial_out_oe_n),
      .lnk(u_link_if.link)
   );

   // split the captured word into its fields
   always_comb begin
      chan = st.word[QDC_POS_CH_HI:QDC_POS_CH_LO];
      cmd = st.word[QDC_POS_CMD_HI:QDC_POS_CMD_LO];
      data = st.word[QDC_POS_DATA_MSB:QDC_POS_DATA_LSB];
      mask = fn_chan_mask(chan);
      strobe_high = st.ld_s2;
   end

   // next state: pin synchronisers, sequencer, command execution
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;

      // chip select and strobe each pass two flops
      next_st.cs_s1 = i_cs_n;
      next_st.cs_s2 = st.cs_s1;
      next_st.cs_d = st.cs_s2;
      next_st.ld_s1 = i_dac_load_strobe_n;
      next_st.ld_s2 = st.ld_s1;

      case (st.state)
         QDC_ST_IDLE: begin
            // wait for a frame to open
            if (!st.cs_s2) begin
               next_st.state = QDC_ST_FRAME;
            end
         end
         QDC_ST_FRAME: begin
            // word is frozen once chip select is high again
            if (st.cs_s2 && !st.cs_d) begin
               next_st.word = u_link_if.word;
               next_st.state = QDC_ST_EXEC;
            end
         end
         QDC_ST_EXEC: begin
            next_st.done = 1'b1;
            next_st.state = QDC_ST_IDLE;
            case (cmd)
               QDC_CMD_BROADCAST: begin
                  // strobe ignored; low channel bit 1 is the do_nothing_command
                  if (!chan[0]) begin
                     for (int i = 0; i < QDC_CHANNELS; i++) begin
                        next_st.in_reg[i] = data;
                        next_st.dac_reg[i] = data;
                     end
                  end
               end
               QDC_CMD_LOAD_INPUT: begin
                  for (int i = 0; i < QDC_CHANNELS; i++) begin
                     if (mask[i]) begin
                        next_st.in_reg[i] = data;
                        if (!strobe_high) begin
                           next_st.dac_reg[i] = data;
                        end
                     end
                  end
               end
               QDC_CMD_LOAD_UPDATE: begin
                  for (int i = 0; i < QDC_CHANNELS; i++) begin
                     if (mask[i]) begin
                        next_st.in_reg[i] = data;
                        if (!strobe_high) begin
                           next_st.dac_reg[i] = data;
                        end
                     end
                  end
                  if (strobe_high) begin
                     next_st.dac_reg = fn_update_all(next_st.in_reg);
                  end
               end
               QDC_CMD_UPDATE: begin
                  // edge selection also updates, whatever the strobe
                  if (chan == QDC_SEL_EDGE_RISING) begin
                     next_st.edge_falling = 1'b0;
                  end else if (chan == QDC_SEL_EDGE_FALLING) begin
                     next_st.edge_falling = 1'b1;
                  end
                  next_st.dac_reg = fn_update_all(next_st.in_reg);
               end
               default: begin
                  next_st.state = QDC_ST_IDLE;
               end
            endcase
         end
         default: begin
            next_st.state = QDC_ST_IDLE;
         end
      endcase

      // low strobe keeps converter registers transparent
      if (!st.ld_s2) begin
         next_st.dac_reg = fn_update_all(next_st.in_reg);
      end
   end

   // register the whole state
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         st <= '{
            in_reg: {QDC_CHANNELS{QDC_CODE_RST}},
            dac_reg: {QDC_CHANNELS{QDC_CODE_RST}},
            edge_falling: QDC_EDGE_FALLING_RST,
            cs_s1: QDC_PIN_IDLE,
            cs_s2: QDC_PIN_IDLE,
            cs_d: QDC_PIN_IDLE,
            ld_s1: QDC_PIN_IDLE,
            ld_s2: QDC_PIN_IDLE,
            state: QDC_ST_IDLE,
            done: 1'b0,
            word: '0
         };
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from state flops
   assign u_link_if.edge_falling = st.edge_falling;
   assign o_dac_code = st.dac_reg;
   assign o_input_code = st.in_reg;
   assign o_edge_falling = st.edge_falling;
   assign o_cmd_done = st.done;

endmodule

// ---- inc/qdc_pkg.sv ----
// constants, types and reset values for the quad converter serial control
package qdc_pkg;

   // word layout, most significant bit first on the wire
   localparam int QDC_WORD_BITS = 16;
   localparam int QDC_DATA_BITS = 12;
   localparam int QDC_CHANNELS = 4;
   localparam int QDC_CH_W = 2;
   localparam int QDC_CMD_W = 2;

   // field positions inside the 16-bit word
   localparam int QDC_POS_CH_HI = 15;
   localparam int QDC_POS_CH_LO = 14;
   localparam int QDC_POS_CMD_HI = 13;
   localparam int QDC_POS_CMD_LO = 12;
   localparam int QDC_POS_DATA_MSB = 11;
   localparam int QDC_POS_DATA_LSB = 0;

   // command bit pairs {command_bit_hi, command_bit_lo}
   localparam logic [1:0] QDC_CMD_BROADCAST = 2'h0;
   localparam logic [1:0] QDC_CMD_LOAD_INPUT = 2'h1;
   localparam logic [1:0] QDC_CMD_UPDATE = 2'h2;
   localparam logic [1:0] QDC_CMD_LOAD_UPDATE = 2'h3;

   // channel selections that pick the output edge
   localparam logic [1:0] QDC_SEL_EDGE_RISING = 2'h3;
   localparam logic [1:0] QDC_SEL_EDGE_FALLING = 2'h2;

   // reset values
   localparam logic [QDC_DATA_BITS-1:0] QDC_CODE_RST = 12'h000;
   localparam logic QDC_EDGE_FALLING_RST = 1'h0;
   localparam logic QDC_PIN_IDLE = 1'h1;

   // command sequencer, gray along idle, frame, execute
   typedef enum logic [1:0] {
      QDC_ST_IDLE = 2'h0,
      QDC_ST_FRAME = 2'h1,
      QDC_ST_EXEC = 2'h3
   } qdc_state_t;

   typedef logic [QDC_CHANNELS-1:0][QDC_DATA_BITS-1:0] qdc_codes_t;

   // whole state of the system-clock side
   typedef struct packed {
      qdc_codes_t in_reg;
      qdc_codes_t dac_reg;
      logic edge_falling;
      logic cs_s1;
      logic cs_s2;
      logic cs_d;
      logic ld_s1;
      logic ld_s2;
      qdc_state_t state;
      logic done;
      logic [QDC_WORD_BITS-1:0] word;
   } qdc_core_t;

   // whole rising-edge state of the serial-clock side
   typedef struct packed {
      logic [QDC_WORD_BITS-1:0] shreg;
      logic out_rise;
      logic rst_s1;
      logic rst_s2;
      logic mode_s1;
      logic mode_s2;
   } qdc_link_t;

endpackage

// ---- inc/qdc_link_if.sv ----
// carrier between the serial-clock side and the system-clock side
`timescale 1ns/1ps
interface qdc_link_if;
   logic [15:0] word;
   logic edge_falling;

   modport link (
      output word,
      input edge_falling
   );
   modport core (
      input word,
      output edge_falling
   );
endinterface

// ---- logic/qdc_serial_link.sv ----
// shift register and serial output on the serial clock
`timescale 1ns/1ps
module qdc_serial_link
   import qdc_pkg::*;
(
   input wire logic i_sclk, // serial clock from host
   input wire logic i_rst_n, // system reset, synchronised here
   input wire logic i_cs_n, // chip select, framed with i_sclk
   input wire logic i_serial_in, // serial data in
   output logic o_serial_out, // serial data out level
   output logic o_serial_out_oe_n, // low while driving
   qdc_link_if.link lnk // word out, edge mode in
);

   qdc_link_t st;
   qdc_link_t next_st;
   logic out_fall;

   // shift while selected, msb first; output trails by 16 edges
   always_comb begin
      next_st = st;
      next_st.rst_s1 = i_rst_n;
      next_st.rst_s2 = st.rst_s1;
      next_st.mode_s1 = lnk.edge_falling;
      next_st.mode_s2 = st.mode_s1;
      if (!i_cs_n) begin
         next_st.shreg = {st.shreg[QDC_WORD_BITS-2:0], i_serial_in};
         next_st.out_rise = st.shreg[QDC_WORD_BITS-1];
      end
      // reset seen here forces rising mode; shifting goes on so no bit of a first frame is lost
      if (!st.rst_s2) begin
         next_st.mode_s1 = QDC_EDGE_FALLING_RST;
         next_st.mode_s2 = QDC_EDGE_FALLING_RST;
      end
   end

   // reset and output mode each arrive through two flops of this domain
   always_ff @(posedge i_sclk) begin
      st <= next_st;
   end

   // half-cycle later copy for falling-edge mode
   always_ff @(negedge i_sclk) begin
      out_fall <= st.out_rise;
   end

   // pass-through for chaining, released while deselected
   assign o_serial_out = i_cs_n ? QDC_PIN_IDLE : (st.mode_s2 ? out_fall : st.out_rise);
   assign o_serial_out_oe_n = i_cs_n;
   assign lnk.word = st.shreg;

endmodule

// ---- verification/qdc_top_checker.sv ----
// concurrent checks on the quad converter control ports
`timescale 1ns/1ps
module qdc_top_checker
   import qdc_pkg::*;
#(
   parameter int DATA_W = QDC_DATA_BITS, // code width
   parameter int CHANNELS = QDC_CHANNELS // converters
)
(
   input wire logic i_clk_sys, // system clock
   input wire logic i_rst_n, // reset
   input wire logic i_sclk, // serial clock
   input wire logic i_cs_n, // chip select
   input wire logic i_serial_in, // serial in
   input wire logic i_dac_load_strobe_n, // load strobe
   input wire logic o_serial_out, // serial out
   input wire logic o_serial_out_oe_n, // out enable
   input wire logic [CHANNELS-1:0][DATA_W-1:0] o_dac_code, // dac codes
   input wire logic [CHANNELS-1:0][DATA_W-1:0] o_input_code, // input codes
   input wire logic o_edge_falling, // edge mode
   input wire logic o_cmd_done // command pulse
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);
   // output pin released and idle high outside frames
   oe_follows_cs_a: assert property (o_serial_out_oe_n == i_cs_n) else $error("oe not cs");
   idle_out_high_a: assert property (i_cs_n |-> o_serial_out) else $error("serial out idle low");
   // execution tied to the end of a frame
   done_pulse_a: assert property (o_cmd_done |=> !o_cmd_done) else $error("done too long");
   done_after_cs_a: assert property ($rose(i_cs_n) |-> ##[3:5] o_cmd_done) else $error("no done");
   done_needs_cs_a: assert property (o_cmd_done |-> $past(i_cs_n, 2)) else $error("done in frame");
   // registers move only on a command, or by the strobe
   input_on_cmd_a: assert property ($changed(o_input_code) |-> o_cmd_done) else $error("input moved");
   mode_on_cmd_a: assert property ($changed(o_edge_falling) |-> o_cmd_done) else $error("mode moved");
   dac_transparent_a: assert property (!i_dac_load_strobe_n [*5] |-> o_dac_code == o_input_code)
      else $error("dac not transparent");
   dac_latched_a: assert property (i_dac_load_strobe_n [*5] ##0 !o_cmd_done |-> $stable(o_dac_code))
      else $error("dac not latched");
endmodule

bind qdc_top qdc_top_checker #(.DATA_W(DATA_W), .CHANNELS(CHANNELS)) chk_i (.i_clk_sys(i_clk_sys),
   .i_rst_n(i_rst_n), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_serial_in(i_serial_in),
   .i_dac_load_strobe_n(i_dac_load_strobe_n), .o_serial_out(o_serial_out),
   .o_serial_out_oe_n(o_serial_out_oe_n), .o_dac_code(o_dac_code), .o_input_code(o_input_code),
   .o_edge_falling(o_edge_falling), .o_cmd_done(o_cmd_done));

// ---- verification/qdc_host_model.sv ----
// host serial master driving the converter serial port
`timescale 1ns/1ps
module qdc_host_model (
   output logic o_sclk, // serial clock, still between frames
   output logic o_cs_n, // chip select
   output logic o_serial_in, // data to the device
   input wire logic i_serial_out // data echoed back
);
   logic [31:0] rx_fall; // echo seen before falling edges
   logic [31:0] rx_rise; // echo seen before rising edges
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_serial_in = 1'b1;
   end
   // one frame msb first, 15 ns clock, select held low throughout
   task automatic xfer(input int n, input logic [31:0] d);
      o_cs_n = 1'b0;
      #30;
      for (int k = n - 1; k >= 0; k--) begin
         o_serial_in = d[k];
         #7.5;
         rx_rise = {rx_rise[30:0], i_serial_out};
         o_sclk = 1'b1;
         #7.5;
         rx_fall = {rx_fall[30:0], i_serial_out};
         o_sclk = 1'b0;
      end
      #7.5;
      o_cs_n = 1'b1;
      o_serial_in = ~o_serial_in; // released line shows no stale level
   endtask
endmodule

// ---- verification/tb_qdc_top.sv ----
// self-checking bench for the quad converter serial control
`timescale 1ns/1ps
module tb_qdc_top;
   import qdc_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_rst_n = 1'b0;
   logic strobe_n = 1'b1;
   logic sclk, cs_n, serial_in, serial_out, oe_n, edge_f, done;
   qdc_codes_t dac, inp, ein = '0, edac = '0;
   int num_errors = 0;
   int samples_checked = 0;
   // 50 MHz system clock
   always #10 i_clk_sys = ~i_clk_sys;
   qdc_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_serial_in(serial_in), .i_serial_out(serial_out));
   qdc_top dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_serial_in(serial_in),
      .i_dac_load_strobe_n(strobe_n), .o_serial_out(serial_out), .o_serial_out_oe_n(oe_n), .o_dac_code(dac),
      .o_input_code(inp), .o_edge_falling(edge_f), .o_cmd_done(done));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // one frame, then a bounded wait for execution
   task automatic cmd(input logic [31:0] d, input int n = 16);
      bit seen;
      seen = 0;
      host.xfer(n, d);
      for (int i = 0; i < 20 && !seen; i++) begin
         @(negedge i_clk_sys);
         seen = (done === 1'b1);
      end
      chk("cmd done", 1'h1, seen);
      if (!seen) conclude();
      chk("released out", 2'h3, {oe_n, serial_out});
      repeat (4) @(negedge i_clk_sys);
   endtask
   task automatic regs();
      for (int c = 0; c < 4; c++) begin
         chk("input code", ein[c], inp[c]);
         chk("dac code", edac[c], dac[c]);
      end
   endtask
   // reset values, then input loads for every channel
   task automatic t_load();
      regs();
      chk("edge mode", 1'h0, edge_f);
      for (int c = 0; c < 4; c++) begin
         ein[c] = 12'hA50 + 12'(c);
         cmd({2'(c), 2'h1, ein[c]});
      end
      regs();
      cmd({2'h1, 2'h2, 12'h000});
      edac = ein;
      regs();
      ein[0] = 12'h0F0;
      cmd({2'h0, 2'h1, ein[0]});
      ein[2] = 12'h123;
      cmd({2'h2, 2'h3, ein[2]});
      edac = ein;
      regs();
      $display("load test done");
   endtask
   // broadcast load, do-nothing, transparency and direct loads
   task automatic t_strobe();
      cmd({2'h2, 2'h0, 12'h3C3});
      ein = {4{12'h3C3}};
      edac = ein;
      cmd({2'h1, 2'h0, 12'h777});
      regs();
      ein[3] = 12'h81E;
      cmd({2'h3, 2'h1, ein[3]});
      regs();
      strobe_n = 1'b0;
      repeat (5) @(negedge i_clk_sys);
      edac = ein;
      regs();
      ein[1] = 12'h5A5;
      cmd({2'h1, 2'h1, ein[1]});
      ein[0] = 12'hC0D;
      cmd({2'h0, 2'h3, ein[0]});
      edac = ein;
      regs();
      strobe_n = 1'b1;
      repeat (5) @(negedge i_clk_sys);
      ein[2] = 12'hFFF;
      cmd({2'h2, 2'h1, ein[2]});
      regs();
      $display("strobe test done");
   endtask
   // edge modes and the echo delay through serial out
   task automatic t_mode();
      logic [31:0] d;
      d = 32'hC35A4000;
      cmd({2'h2, 2'h2, 12'h000});
      edac = ein;
      regs();
      chk("edge mode", 1'h1, edge_f);
      cmd(d, 32);
      chk("falling echo", d[31:17], host.rx_rise[14:0]);
      cmd({2'h3, 2'h2, 12'h000});
      chk("edge mode", 1'h0, edge_f);
      cmd(d, 32);
      chk("rising echo", d[31:16], host.rx_fall[15:0]);
      regs();
      $display("mode test done");
   endtask
   initial begin
      // dummy frame lets the link side see reset
      fork
         host.xfer(16, 32'h00004000);
         repeat (16) @(negedge i_clk_sys);
      join
      i_rst_n = 1'b1;
      repeat (4) @(negedge i_clk_sys);
      t_load();
      t_strobe();
      t_mode();
      conclude();
   end
endmodule
